// *** common/tx_cfg_pkg.sv ***
// Shared constants and carriers for the transmit packet framer and its register port.
// Assumes a byte-wide register port driven by logic on the same clock as the framer.
package tx_cfg_pkg;
  localparam logic [5:0] off_sync_high = 6'h04;
  localparam logic [5:0] off_sync_low = 6'h05;
  localparam logic [5:0] off_pkt_len = 6'h06;
  localparam logic [5:0] off_pkt_ctrl = 6'h08;
  localparam logic [5:0] off_addr = 6'h09;
  localparam logic [5:0] off_channel_index = 6'h0a;
  localparam logic [5:0] off_carrier_high = 6'h0d;
  localparam logic [5:0] off_carrier_mid = 6'h0e;
  localparam logic [5:0] off_carrier_low = 6'h0f;
  localparam logic [5:0] off_rate_exp = 6'h10;
  localparam logic [5:0] off_rate_mant = 6'h11;
  localparam logic [5:0] off_channel_index_spacing = 6'h15;

  localparam logic [7:0] rst_sync_high = 8'hd3;
  localparam logic [7:0] rst_sync_low = 8'h91;
  localparam logic [7:0] rst_pkt_len = 8'hff;
  localparam logic [7:0] rst_addr = 8'h00;
  localparam logic [7:0] rst_channel_index = 8'h00;
  localparam logic [5:0] rst_carrier_high = 6'h1e;
  localparam logic [7:0] rst_carrier_mid = 8'hc4;
  localparam logic [7:0] rst_carrier_low = 8'hec;
  localparam logic [3:0] rst_rate_exp = 4'hc;
  localparam logic [7:0] rst_rate_mant = 8'h22;
  localparam logic [7:0] rst_channel_index_spacing = 8'hf8;
  localparam logic [0:0] rst_whitening = 1'h1;
  localparam logic [1:0] rst_format = 2'h0;
  localparam logic [0:0] rst_crc_en = 1'h1;
  localparam logic [1:0] rst_len_mode = 2'h1;

  localparam int ctrl_white_bit = 6;
  localparam int ctrl_fmt_lsb = 4;
  localparam int ctrl_crc_bit = 2;

  localparam logic [1:0] fmt_fifo = 2'h0;
  localparam logic [1:0] fmt_sync_serial = 2'h1;
  localparam logic [1:0] fmt_random = 2'h2;
  localparam logic [1:0] fmt_async = 2'h3;
  localparam logic [1:0] len_fixed = 2'h0;
  localparam logic [1:0] len_variable = 2'h1;
  localparam logic [1:0] len_infinite = 2'h2;

  localparam logic [8:0] pn9_seed = 9'h1ff;
  localparam logic [15:0] crc_seed = 16'hffff;
  localparam logic [15:0] crc_poly = 16'h8005;
  localparam logic [7:0] preamble_byte = 8'haa;
  localparam logic [2:0] preamble_bytes = 3'h4;
  localparam logic [8:0] rate_hidden_one = 9'h100;

  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic whitening_enable;
    logic [1:0] data_source_format;
    logic crc_en;
    logic [1:0] len_mode;
  } pkt_ctrl_t;

  typedef struct packed {
    logic [23:0] carrier_word;
    logic [7:0] channel_index;
    logic [7:0] channel_index_spacing;
    logic [8:0] symbol_rate_mantissa;
    logic [3:0] symbol_rate_exponent;
  } synth_cfg_t;
endpackage

// *** design/tx_packet_synth_config.sv ***
// Register file, packet framer and synthesizer settings of the transmitter.
// Assumes the register port and payload stream are on clk; the serial data pin is asynchronous.
`timescale 1ns/1ps
// What this block does
// (RULE_01) Low sync byte is a read/write register resetting to 0x91.
// (RULE_02) High sync byte is a separate read/write register; together they form the word.
// (RULE_03) Fixed framing sends exactly the packet length setting bytes.
// (RULE_04) Variable framing uses the packet length setting only as the maximum.
// (RULE_05) Whitening bit, reset one, selects whitening of transmitted data.
// (RULE_06) Format 00 takes data from the transmit FIFO in packet mode.
// (RULE_07) Format 01 is serial synchronous; data comes in on general output pin zero.
// (RULE_08) Format 10 transmits PN9 pseudo-random data for test.
// (RULE_09) Format 11 passes pin zero data straight to the transmitter.
// (RULE_10) CRC enable bit, reset one, inserts a CRC per packet.
// (RULE_11) Length mode 00 sends fixed length packets.
// (RULE_12) Length mode 01, the reset value, sends a leading length byte.
// (RULE_13) Length mode 10 sends unbounded packets; host never writes 11.
// (RULE_14) Filter address register is eight bits resetting to zero.
// (RULE_15) Channel number times spacing is added to the base frequency.
// (RULE_16) Top two carrier word bits read zero and cannot be written.
// (RULE_17) Carrier is crystal over two to sixteen times the 24-bit word.
// (RULE_18) Low nibble of the modem byte is the rate exponent, reset 0x0c.
// (RULE_19) Upper nibble of the exponent byte is reserved, read only.
// (RULE_20) Symbol rate has eight-bit mantissa plus a hidden leading one.
// (RULE_21) Sixteen-bit CRC follows payload, over length and payload, before whitening.
// (RULE_22) Sync word goes high byte first, MSB first, after preamble.
module tx_packet_synth_config
  import tx_cfg_pkg::*;
#(
  parameter int fifo_depth = 2
) (
  input wire logic clk,               // 200 MHz clock
  input wire logic resetn,            // Asynchronous reset, active low
  input wire reg_req_t reg_req,       // Register access request
  input wire logic reg_valid,         // Register request strobe
  output logic [7:0] reg_rdata,       // Read data, one cycle after the request
  output logic reg_rvalid,            // Read data valid pulse
  input wire logic tx_start,          // Begin a packet (packet formats)
  input wire logic [7:0] fifo_data,   // Payload byte from transmit FIFO
  input wire logic fifo_valid,        // Payload byte available
  output logic fifo_ready,            // Payload byte accepted
  input wire logic [7:0] pay_len,     // Payload length for variable mode
  input wire logic general_output_pin_zero_in,           // General output pin zero data input
  input wire logic bit_tick,          // Symbol clock strobe from the modulator
  output logic tx_bit_ff,             // Bit to the modulator
  output logic tx_active_ff,          // Transmission in progress
  output logic pkt_done_ff,           // Packet finished pulse
  output logic [31:0] synth_word_ff,  // Carrier plus channel offset, in fxosc/2^18 steps
  output synth_cfg_t synth_cfg_ff     // Synthesizer and rate settings
);
  // The skid buffer is built for exactly two entries
  if (fifo_depth != 2) begin : g_depth_check
    $error("fifo_depth must be 2");
  end

  typedef enum logic [5:0] {
    st_idle = 6'b000001,
    st_pre = 6'b000010,
    st_sync = 6'b000100,
    st_len = 6'b001000,
    st_data = 6'b010000,
    st_crc = 6'b100000
  } fr_state_t;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ crc_poly) : (r << 1);
    end
    return r;
  endfunction

  logic [7:0] sync_high_ff, sync_low_ff, pkt_len_ff, addr_ff, channel_index_ff;
  logic [5:0] carrier_high_ff;
  logic [7:0] carrier_mid_ff, carrier_low_ff, rate_mant_ff, spacing_ff;
  logic [3:0] rate_exp_ff;
  pkt_ctrl_t ctrl_ff;
  logic [1:0] gdo_sync_ff;

  // Register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_high_ff <= rst_sync_high;
      sync_low_ff <= rst_sync_low;
      pkt_len_ff <= rst_pkt_len;
      addr_ff <= rst_addr;
      channel_index_ff <= rst_channel_index;
      carrier_high_ff <= rst_carrier_high;
      carrier_mid_ff <= rst_carrier_mid;
      carrier_low_ff <= rst_carrier_low;
      rate_exp_ff <= rst_rate_exp;
      rate_mant_ff <= rst_rate_mant;
      spacing_ff <= rst_channel_index_spacing;
      ctrl_ff <= {rst_whitening, rst_format, rst_crc_en, rst_len_mode};
    end else if (reg_valid && reg_req.wr) begin
      unique case (reg_req.addr)
        off_sync_high: sync_high_ff <= reg_req.wdata; // see RULE_02
        off_sync_low: sync_low_ff <= reg_req.wdata; // see RULE_01
        off_pkt_len: pkt_len_ff <= reg_req.wdata;
        off_pkt_ctrl: ctrl_ff <= {reg_req.wdata[ctrl_white_bit],
                                  reg_req.wdata[ctrl_fmt_lsb +: 2],
                                  reg_req.wdata[ctrl_crc_bit],
                                  reg_req.wdata[1:0]};
        off_addr: addr_ff <= reg_req.wdata; // see RULE_14
        off_channel_index: channel_index_ff <= reg_req.wdata;
        off_carrier_high: carrier_high_ff <= reg_req.wdata[5:0]; // see RULE_16
        off_carrier_mid: carrier_mid_ff <= reg_req.wdata;
        off_carrier_low: carrier_low_ff <= reg_req.wdata;
        off_rate_exp: rate_exp_ff <= reg_req.wdata[3:0]; // see RULE_18 RULE_19
        off_rate_mant: rate_mant_ff <= reg_req.wdata;
        off_channel_index_spacing: spacing_ff <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped offsets read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_valid && !reg_req.wr;
      // Read data only moves on a read, so it stands until the next read
      if (reg_valid && !reg_req.wr) begin
        unique case (reg_req.addr)
          off_sync_high: reg_rdata <= sync_high_ff;
          off_sync_low: reg_rdata <= sync_low_ff;
          off_pkt_len: reg_rdata <= pkt_len_ff;
          off_pkt_ctrl: reg_rdata <= {1'b0, ctrl_ff.whitening_enable, ctrl_ff.data_source_format,
                                      1'b0, ctrl_ff.crc_en, ctrl_ff.len_mode};
          off_addr: reg_rdata <= addr_ff;
          off_channel_index: reg_rdata <= channel_index_ff;
          off_carrier_high: reg_rdata <= {2'b00, carrier_high_ff}; // see RULE_16
          off_carrier_mid: reg_rdata <= carrier_mid_ff;
          off_carrier_low: reg_rdata <= carrier_low_ff;
          off_rate_exp: reg_rdata <= {4'h0, rate_exp_ff}; // see RULE_19
          off_rate_mant: reg_rdata <= rate_mant_ff;
          off_channel_index_spacing: reg_rdata <= spacing_ff;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Synthesizer word: base in fxosc/2^16 steps scaled by 4 to share the 2^18 channel grid
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      synth_word_ff <= 32'h0000_0000;
      synth_cfg_ff <= '0;
    end else begin
      synth_cfg_ff.carrier_word <= {2'b00, carrier_high_ff, carrier_mid_ff,
                                    carrier_low_ff}; // see RULE_17
      synth_cfg_ff.channel_index <= channel_index_ff;
      synth_cfg_ff.channel_index_spacing <= spacing_ff;
      synth_cfg_ff.symbol_rate_mantissa <= rate_hidden_one | {1'b0, rate_mant_ff}; // see RULE_20
      synth_cfg_ff.symbol_rate_exponent <= rate_exp_ff; // see RULE_18
      // Operands widened before the product so no channel offset bit is lost
      synth_word_ff <= {8'h00, carrier_high_ff, carrier_mid_ff, carrier_low_ff, 2'b00}
                       + {16'h0000, 16'(channel_index_ff) * 16'(spacing_ff)}; // see RULE_15 RULE_17
    end
  end

  // Pin data crosses into clk through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) gdo_sync_ff <= 2'b00;
    else gdo_sync_ff <= {gdo_sync_ff[0], general_output_pin_zero_in};
  end

  // Two-entry skid buffer in front of the framer so a stall loses no byte
  logic [7:0] buf_mem [2];
  logic [1:0] buf_cnt_ff;
  logic buf_wp_ff, buf_rp_ff;
  logic buf_pop;
  logic ready_ff;
  // Ready comes from a flop that tracks the count, high while fewer than two bytes are held
  assign fifo_ready = ready_ff;
  wire buf_push = fifo_valid && ready_ff;
  wire [1:0] nxt_buf_cnt = buf_cnt_ff + 2'(buf_push) - 2'(buf_pop);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      buf_cnt_ff <= 2'd0;
      buf_wp_ff <= 1'b0;
      buf_rp_ff <= 1'b0;
      ready_ff <= 1'b1;
    end else begin
      if (buf_push) buf_wp_ff <= ~buf_wp_ff;
      if (buf_pop) buf_rp_ff <= ~buf_rp_ff;
      buf_cnt_ff <= nxt_buf_cnt;
      ready_ff <= (nxt_buf_cnt != 2'd2);
    end
  end
  always_ff @(posedge clk) begin
    if (buf_push) buf_mem[buf_wp_ff] <= fifo_data; // see RULE_06
  end
  wire buf_has = (buf_cnt_ff != 2'd0);

  // Framer
  fr_state_t st_ff;
  logic [7:0] sh_ff, remain_ff;
  logic [2:0] bit_ff, pre_cnt_ff;
  logic sync_half_ff, crc_half_ff;
  logic [15:0] crc_ff;
  logic [8:0] pn9_ff;
  wire pkt_mode = (ctrl_ff.data_source_format == fmt_fifo)
                  || (ctrl_ff.data_source_format == fmt_random);
  wire byte_end = bit_tick && (bit_ff == 3'd7);
  wire white_bit = sh_ff[7] ^ (ctrl_ff.whitening_enable && (st_ff == st_len || st_ff == st_data)
                   ? pn9_ff[0] : 1'b0); // see RULE_05
  wire [7:0] len_used = (pay_len > pkt_len_ff) ? pkt_len_ff : pay_len; // see RULE_04
  // Infinite packets run on while tx_start stays high; others count down the length
  wire more_data = (ctrl_ff.len_mode == len_infinite) ? tx_start
                   : (remain_ff > 8'd1); // see RULE_13
  // Pop exactly when a buffered byte is loaded into the shifter, never on a stale reload
  assign buf_pop = byte_end && buf_has && (ctrl_ff.data_source_format == fmt_fifo)
                   && ((st_ff == st_sync && sync_half_ff && ctrl_ff.len_mode != len_variable)
                       || st_ff == st_len || (st_ff == st_data && more_data));
  wire [7:0] next_data = (ctrl_ff.data_source_format == fmt_random) ? pn9_ff[7:0]
                         : buf_mem[buf_rp_ff]; // see RULE_08
  wire [8:0] pn9_step = {pn9_ff[5] ^ pn9_ff[0], pn9_ff[8:1]};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= st_idle;
      sh_ff <= 8'h00;
      bit_ff <= 3'd0;
      pre_cnt_ff <= 3'd0;
      sync_half_ff <= 1'b0;
      crc_half_ff <= 1'b0;
      remain_ff <= 8'h00;
      crc_ff <= crc_seed;
      tx_active_ff <= 1'b0;
      pkt_done_ff <= 1'b0;
    end else begin
      pkt_done_ff <= 1'b0;
      if (bit_tick && st_ff != st_idle) bit_ff <= bit_ff + 3'd1;
      if (bit_tick && st_ff != st_idle && !byte_end) sh_ff <= {sh_ff[6:0], 1'b0};
      unique case (st_ff)
        st_idle: begin
          tx_active_ff <= !pkt_mode;
          if (tx_start && pkt_mode) begin
            st_ff <= st_pre;
            sh_ff <= preamble_byte;
            bit_ff <= 3'd0;
            pre_cnt_ff <= 3'd1;
            crc_ff <= crc_seed;
            tx_active_ff <= 1'b1;
          end
        end
        st_pre: if (byte_end) begin
          if (pre_cnt_ff == preamble_bytes) begin
            st_ff <= st_sync;
            sh_ff <= sync_high_ff; // see RULE_22
            sync_half_ff <= 1'b0;
          end else begin
            pre_cnt_ff <= pre_cnt_ff + 3'd1;
            sh_ff <= preamble_byte;
          end
        end
        st_sync: if (byte_end) begin
          if (!sync_half_ff) begin
            sh_ff <= sync_low_ff; // see RULE_22
            sync_half_ff <= 1'b1;
          end else if (ctrl_ff.len_mode == len_variable) begin
            st_ff <= st_len; // see RULE_12
            sh_ff <= len_used;
            remain_ff <= len_used;
            crc_ff <= crc_byte(crc_seed, len_used); // see RULE_21
          end else begin
            st_ff <= st_data; // see RULE_11 RULE_13
            remain_ff <= pkt_len_ff; // see RULE_03
            sh_ff <= next_data;
            crc_ff <= crc_byte(crc_seed, next_data);
          end
        end
        st_len: if (byte_end) begin
          st_ff <= st_data;
          sh_ff <= next_data;
          crc_ff <= crc_byte(crc_ff, next_data);
        end
        st_data: if (byte_end) begin
          if (more_data) begin
            if (ctrl_ff.len_mode != len_infinite) remain_ff <= remain_ff - 8'd1;
            sh_ff <= next_data;
            crc_ff <= crc_byte(crc_ff, next_data);
          end else if (ctrl_ff.crc_en) begin
            st_ff <= st_crc; // see RULE_10 RULE_21
            sh_ff <= crc_ff[15:8];
            crc_half_ff <= 1'b0;
          end else begin
            st_ff <= st_idle;
            pkt_done_ff <= 1'b1;
          end
        end
        st_crc: if (byte_end) begin
          if (!crc_half_ff) begin
            sh_ff <= crc_ff[7:0];
            crc_half_ff <= 1'b1;
          end else begin
            st_ff <= st_idle;
            pkt_done_ff <= 1'b1;
          end
        end
      endcase
    end
  end

  // Bit to the modulator: pin data in the serial formats, framed bits otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_bit_ff <= 1'b0;
    end else if (bit_tick) begin
      if (!pkt_mode) begin
        tx_bit_ff <= gdo_sync_ff[1]; // see RULE_07 RULE_09
      end else if (st_ff != st_idle) begin
        tx_bit_ff <= white_bit;
      end
    end
  end

  // Sequence restarts with every packet so whitening and test data repeat exactly
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pn9_ff <= pn9_seed;
    end else if (st_ff == st_idle && tx_start && pkt_mode) begin
      pn9_ff <= pn9_seed;
    end else if (byte_end && (st_ff == st_len || st_ff == st_data)
                 && (ctrl_ff.whitening_enable
                     || ctrl_ff.data_source_format == fmt_random)) begin
      pn9_ff <= pn9_step; // see RULE_05 RULE_08
    end
  end
endmodule

// *** bench/tx_cfg_monitor.sv ***
// Port assertions for the transmit framer and register file.
// Bound onto the top module below; sees its ports only.
`timescale 1ns/1ps
module tx_cfg_monitor
  import tx_cfg_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire reg_req_t reg_req, // Register request
  input wire logic reg_valid, // Request strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read pulse
  input wire logic bit_tick, // Symbol strobe
  input wire logic tx_bit_ff, // Bit out
  input wire logic tx_active_ff, // Sending
  input wire logic pkt_done_ff, // Done pulse
  input wire logic [31:0] synth_word_ff, // Synth word
  input wire synth_cfg_t synth_cfg_ff // Synth settings
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rd_req;
  assign rd_req = reg_valid && !reg_req.wr;
  read_answer_a: assert property (rd_req |=> reg_rvalid)
    else $error("read not answered");
  write_silent_a: assert property (reg_valid && reg_req.wr |=> !reg_rvalid)
    else $error("write gave read pulse");
  carrier_top_a: assert property (rd_req && reg_req.addr == off_carrier_high
    |=> reg_rdata[7:6] == 2'h0) else $error("carrier top bits not zero");
  rate_upper_a: assert property (rd_req && reg_req.addr == off_rate_exp
    |=> reg_rdata[7:4] == 4'h0) else $error("rate upper nibble not zero");
  synth_sum_a: assert property ($stable(synth_cfg_ff) ##1 $stable(synth_cfg_ff)
    |-> synth_word_ff == 32'(synth_cfg_ff.carrier_word) * 4
    + 32'(synth_cfg_ff.channel_index) * 32'(synth_cfg_ff.channel_index_spacing))
    else $error("synth word wrong");
  carrier_width_a: assert property (synth_cfg_ff.carrier_word[23:22] == 2'h0)
    else $error("carrier word top bits set");
  hidden_one_a: assert property (tx_active_ff |-> synth_cfg_ff.symbol_rate_mantissa[8])
    else $error("mantissa lacks hidden one");
  done_pulse_a: assert property (pkt_done_ff |=> !pkt_done_ff)
    else $error("done pulse too long");
  tick_aligned_a: assert property ($changed(tx_bit_ff) |-> $past(bit_tick))
    else $error("bit moved without strobe");
endmodule
bind tx_packet_synth_config tx_cfg_monitor mon (.clk, .resetn, .reg_req, .reg_valid,
  .reg_rdata, .reg_rvalid, .bit_tick, .tx_bit_ff, .tx_active_ff, .pkt_done_ff,
  .synth_word_ff, .synth_cfg_ff);

// *** bench/tick_model.sv ***
// Modulator-side model: paces symbols and records every bit handed over.
// Assumes the framer shares clk and moves its bit on the strobe.
`timescale 1ns/1ps
module tick_model (
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic tx_bit_ff, // Bit from framer
  output logic bit_tick // Symbol strobe
);
  logic [1:0] div_ff;
  logic bits [$];
  // One strobe in four cycles leaves the bit time to settle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 2'h0;
      bit_tick <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      bit_tick <= (div_ff == 2'h3);
    end
  end
  always @(posedge clk) begin
    if (bit_tick) begin
      bits.push_back(tx_bit_ff);
    end
  end
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench for the transmit framer and register file.
// Assumes the modulator model paces symbols; the bench is host and payload source.
`timescale 1ns/1ps
module tb_top;
  import tx_cfg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_valid = 1'b0;
  logic tx_start = 1'b0;
  logic fifo_valid = 1'b0;
  logic general_output_pin_zero_in = 1'b0;
  reg_req_t reg_req = '0;
  logic [7:0] fifo_data = 8'h00;
  logic [7:0] pay_len = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid, fifo_ready, bit_tick, tx_bit_ff, tx_active_ff, pkt_done_ff;
  logic [31:0] synth_word_ff;
  synth_cfg_t synth_cfg_ff;
  int num_errors = 0;
  int check_count = 0;
  always #2.5 clk = ~clk;
  tx_packet_synth_config uut (.clk, .resetn, .reg_req, .reg_valid, .reg_rdata, .reg_rvalid,
    .tx_start, .fifo_data, .fifo_valid, .fifo_ready, .pay_len, .general_output_pin_zero_in, .bit_tick,
    .tx_bit_ff, .tx_active_ff, .pkt_done_ff, .synth_word_ff, .synth_cfg_ff);
  tick_model pm (.clk, .resetn, .tx_bit_ff, .bit_tick);
  task automatic check(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_req <= '{1'b1, a, d};
    reg_valid <= 1'b1;
    @(posedge clk);
    reg_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    reg_req <= '{1'b0, a, 8'h00};
    reg_valid <= 1'b1;
    @(posedge clk);
    reg_valid <= 1'b0;
    #1 check(reg_rvalid, 1'b1);
    check(reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic push(input logic [7:0] d);
    fifo_data <= d;
    fifo_valid <= 1'b1;
    @(posedge clk);
    fifo_valid <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [7:0] gb(input int p);
    for (int j = 0; j < 8; j++) gb[7 - j] = (p + j < pm.bits.size()) ? pm.bits[p + j] : 1'bx;
  endfunction
  function automatic logic [7:0] crc_hi(input logic [7:0] d);
    logic [15:0] r;
    r = crc_seed;
    for (int i = 7; i >= 0; i--) r = {r[14:0], 1'b0} ^ (r[15] ^ d[i] ? crc_poly : 16'h0000);
    return r[15:8];
  endfunction
  task automatic t_regs;
    logic [13:0] tbl [12] = '{{off_sync_high, 8'hd3}, {off_sync_low, 8'h91},
      {off_pkt_len, 8'hff}, {off_pkt_ctrl, 8'h45}, {off_addr, 8'h00}, {off_channel_index, 8'h00},
      {off_carrier_high, 8'h1e}, {off_carrier_mid, 8'hc4}, {off_carrier_low, 8'hec},
      {off_rate_exp, 8'h0c}, {off_rate_mant, 8'h22}, {off_channel_index_spacing, 8'hf8}};
    foreach (tbl[i]) rd(tbl[i][13:8], tbl[i][7:0]);
    wr(off_carrier_high, 8'hff);
    rd(off_carrier_high, 8'h3f);
    wr(off_rate_exp, 8'hff);
    rd(off_rate_exp, 8'h0f);
    wr(off_addr, 8'hff);
    rd(off_addr, 8'hff);
    rd(6'h3f, 8'h00);
    wr(off_sync_low, 8'h5a);
    rd(off_sync_low, 8'h5a);
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(off_sync_low, 8'h91);
    rd(off_addr, 8'h00);
  endtask
  task automatic t_synth;
    wr(off_channel_index, 8'h05);
    repeat (3) @(posedge clk);
    check(synth_word_ff, 32'h1ec4ec * 4 + 32'd5 * 32'hf8);
    check(32'(synth_cfg_ff.symbol_rate_mantissa), 32'h122);
    check(32'(synth_cfg_ff.symbol_rate_exponent), 32'hc);
    wr(off_channel_index, 8'h00);
  endtask
  task automatic pkt(input logic [7:0] ctrl, plen, pl, d0, d1, input int n, ne,
      input logic [7:0] e0, e1, input int hold);
    int k;
    wr(off_pkt_ctrl, ctrl);
    wr(off_pkt_len, plen);
    pay_len <= pl;
    for (int i = 0; i < n; i++) push(i == 0 ? d0 : d1);
    if (n == 2) check(fifo_ready, 1'b0);
    pm.bits.delete();
    tx_start <= 1'b1;
    @(posedge clk);
    // Infinite packets keep going while the start level is held
    while (pm.bits.size() < hold) @(posedge clk);
    tx_start <= 1'b0;
    k = 0;
    while (pkt_done_ff !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    check(k < 3000, 1'b1);
    repeat (8) @(posedge clk);
    check(fifo_ready, 1'b1);
    check(tx_active_ff, 1'b0);
    k = 24;
    while (k < pm.bits.size() && {gb(k), gb(k + 8), gb(k + 16)} !== 24'haad391) k++;
    check({gb(k - 24), gb(k - 16), gb(k - 8), gb(k)}, 32'haaaaaaaa);
    check({gb(k + 8), gb(k + 16)}, 16'hd391);
    if (ne > 0) check(gb(k + 24), e0);
    if (ne > 1) check(gb(k + 32), e1);
  endtask
  task automatic t_serial;
    for (int f = 1; f < 4; f += 2) begin
      wr(off_pkt_ctrl, {2'b00, 2'(f), 4'h1});
      general_output_pin_zero_in <= 1'b1;
      repeat (24) @(posedge clk);
      check(tx_bit_ff, 1'b1);
      check(tx_active_ff, 1'b1);
      general_output_pin_zero_in <= 1'b0;
      repeat (24) @(posedge clk);
      check(tx_bit_ff, 1'b0);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_synth();
    pkt(8'h00, 8'h02, 8'h00, 8'h3c, 8'ha5, 2, 2, 8'h3c, 8'ha5, 0);
    pkt(8'h02, 8'h01, 8'h00, 8'h3c, 8'ha5, 2, 2, 8'h3c, 8'ha5, 60);
    pkt(8'h01, 8'h01, 8'h05, 8'h7e, 8'h00, 1, 2, 8'h01, 8'h7e, 0);
    pkt(8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 1, 1, 8'hff, 8'h00, 0);
    pkt(8'h04, 8'h01, 8'h00, 8'h3c, 8'h00, 1, 2, 8'h3c, crc_hi(8'h3c), 0);
    pkt(8'h20, 8'h01, 8'h00, 8'h00, 8'h00, 0, 1, pn9_seed[7:0], 8'h00, 0);
    t_serial();
    results();
  end
  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule
